// file: verif/gpio_led_pin_config_assertions.sv
// Checker for the general pin block: bus answers and pin drive.
// Assumes full-word configuration writes; sees only top-level ports.
`timescale 1ns/100ps
`default_nettype none
module gpio_pin_checker (
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        NRST,
    // Bus
    input wire logic [7:0]  ADDRESS,
    input wire logic        READ,
    input wire logic        WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0]  BYTEENABLE,
    input wire logic [31:0] READDATA,
    input wire logic        WAITREQUEST,
    input wire logic [1:0]  RESPONSE,
    // Pins
    input wire logic [2:0]  PIN_OUT,
    input wire logic [2:0]  PIN_OE,
    input wire logic [2:0]  INDICATOR
);
    logic [31:0] cfg;   // Last full-word configuration write
    logic [1:0]  age;   // Edges since it; registered pins need a few to settle
    wire         req = READ | WRITE;
    wire         known = ADDRESS == 8'h88 || ADDRESS == 8'hA4 || ADDRESS == 8'hA8;
    wire  [2:0]  ind = cfg[30:28];
    // Shadow follows a write at the edge where it is answered
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            cfg <= 32'h0;
            age <= 2'h0;
        end else if (WRITE && !WAITREQUEST && ADDRESS == 8'h88) begin
            cfg <= (BYTEENABLE == 4'hF) ? WRITEDATA : cfg;
            age <= 2'h0;
        end else if (age != 2'h3) begin
            age <= age + 2'h1;
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);
    answer_in_time_a: assert property (req && WAITREQUEST |-> ##[1:2] !WAITREQUEST)
        else $error("request not answered");
    answer_once_a: assert property ($fell(WAITREQUEST) |=> WAITREQUEST)
        else $error("answer stands too long");
    bad_addr_a: assert property (req && !WAITREQUEST && !known |-> RESPONSE == 2'h2 && READDATA == 32'h0)
        else $error("unmapped access not refused");
    good_addr_a: assert property (req && !WAITREQUEST && known |-> RESPONSE == 2'h0)
        else $error("mapped access refused");
    write_zero_a: assert property (WRITE && !WAITREQUEST |-> READDATA == 32'h0)
        else $error("write answered with data");
    spare_zero_a: assert property (
        READ && !WAITREQUEST && ADDRESS == 8'h88 |-> (READDATA & 32'h8888F8E0) == 32'h0)
        else $error("spare bits not zero");
    pin_enable_a: assert property (
        age == 2'h3 |-> PIN_OE == (ind | cfg[10:8] & (cfg[18:16] | ~cfg[2:0])))
        else $error("pin enable wrong");
    pin_drive_a: assert property (
        age == 2'h3 |-> ((PIN_OUT ^ (ind & $past(INDICATOR) | ~ind & cfg[2:0])) & PIN_OE) == 3'h0)
        else $error("driven level wrong");
endmodule
bind gpio_led_pin_config gpio_pin_checker gpio_pin_checker_i (
    .MCLK(MCLK), .NRST(NRST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .BYTEENABLE(BYTEENABLE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .RESPONSE(RESPONSE),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .INDICATOR(INDICATOR));
`default_nettype wire

// file: verif/gpio_led_pin_config_bench.sv
// Self-checking bench for the general pin block.
// Assumes the pin model beside it and the checker bound into the design.
`timescale 1ns/100ps
`default_nettype none
module gpio_led_pin_config_bench;
    logic        mclk = 1'b0;     // 200 MHz block clock
    logic        nrst = 1'b0;     // Low for the first 8 cycles
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [7:0]  address = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;           // Taken at the answer edge
    logic [1:0]  resp;
    logic [2:0]  ext_en = 3'h0;   // Pins driven from outside
    logic [2:0]  ext_val = 3'h0;
    logic [2:0]  indicator = 3'h5;
    logic [5:0]  src = 6'h0;      // ROM data, ROM clock, TX_EN, RX_DV, TX_CLK, RX_CLK
    wire  [31:0] readdata;
    wire  [1:0]  response;
    wire  [2:0]  pin_in, pin_out, pin_oe;
    wire         waitrequest, irq, out3, out4, rom_d, rom_c;
    int          mismatches = 0;
    int          comparisons = 0;
    // Clock
    always #2.5 mclk = ~mclk;
    gpio_led_pin_config gpio_led_pin_config_i (.MCLK(mclk), .NRST(nrst), .ADDRESS(address), .READ(rd),
        .WRITE(wr), .WRITEDATA(wdata), .BYTEENABLE(4'hF), .READDATA(readdata), .WAITREQUEST(waitrequest),
        .RESPONSE(response), .IRQ(irq), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .INDICATOR(indicator), .OUT_ONLY_PIN_3(out3), .OUT_ONLY_PIN_4(out4), .ROM_DATA_SRC(src[5]),
        .ROM_CLK_SRC(src[4]), .TX_EN(src[3]), .RX_DV(src[2]), .TX_CLK(src[1]), .RX_CLK(src[0]),
        .ROM_DATA_PIN(rom_d), .ROM_CLOCK_PIN(rom_c));
    pin_partner pin_partner_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
        .level(pin_in));
    // Compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] time %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Counts, verdict, end of run
    task give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // One transfer, held until waitrequest is sampled low; a hang ends the run
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {address, wdata} <= {a, d};
        {rd, wr} <= {!w, w};
        @(posedge mclk);
        while (waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge mclk);
        end
        if (waitrequest !== 1'b0) begin
            mismatches++;
            give_verdict;
        end
        {rdata, resp} = {readdata, response};
        {rd, wr} <= 2'h0;
        @(posedge mclk);
    endtask
    // Read and compare
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask
    // Reset values, refusal, spare bits, indicator routing
    task t_regs;
        rchk(8'hA8, 32'h0);
        rchk(8'h88, 32'h7);
        bus(1'b1, 8'h90, 32'hFFFFFFFF);
        chk({30'h0, resp}, 32'h2);
        rchk(8'h90, 32'h0);
        bus(1'b1, 8'h88, 32'hFF8FFFFF);
        repeat (6) @(posedge mclk);
        rchk(8'h88, 32'h7707071D);
        chk({29'h0, out4, out3, irq}, 32'h6);
        indicator <= 3'h2;
        repeat (6) @(posedge mclk);
        rchk(8'h88, 32'h7707071A);
    endtask
    // Push/pull and open drain; readback shows the wire, not the data
    task t_pins;
        bus(1'b1, 8'h88, 32'h00070702);
        repeat (6) @(posedge mclk);
        rchk(8'h88, 32'h00070702);
        chk({29'h0, pin_oe}, 32'h7);
        bus(1'b1, 8'h88, 32'h00000702);
        ext_en <= 3'h2;
        repeat (6) @(posedge mclk);
        rchk(8'h88, 32'h00000700);
        chk({29'h0, pin_oe}, 32'h5);
        bus(1'b1, 8'h88, 32'h0);
        repeat (6) @(posedge mclk);
        chk({29'h0, pin_oe}, 32'h0);
    endtask
    // Pin 0 interrupt: both polarities, mask, read to clear
    task t_irq;
        ext_en <= 3'h7;
        ext_val <= 3'h6;
        bus(1'b1, 8'h88, 32'h01000000);
        repeat (20) @(posedge mclk);
        bus(1'b0, 8'hA4, 32'h0);
        bus(1'b1, 8'hA8, 32'h1);
        rchk(8'hA8, 32'h1);
        ext_val <= 3'h7;
        repeat (20) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        rchk(8'hA4, 32'h1);
        ext_val <= 3'h6;
        repeat (20) @(posedge mclk);
        bus(1'b0, 8'hA4, 32'h0);
        rchk(8'hA4, 32'h0);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 8'h88, 32'h0);
        repeat (20) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 8'hA8, 32'h0);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        ext_en <= 3'h0;
    endtask
    // Every legal ROM pin code, sources at both levels
    task t_rom;
        logic [2:0] c;
        logic [5:0] s;
        logic       o3;
        logic [1:0] e;
        for (int k = 0; k < 16; k++) begin
            c = k[2:0];
            o3 = k[3];
            s = o3 ? 6'h2D : 6'h12;
            // Software never picks a reserved code
            if (c == 3'h2 || c == 3'h4) begin
                continue;
            end
            src <= s;
            // No ROM cycle runs here, so the field may change
            bus(1'b1, 8'h88, {9'h0, c, 12'h0, o3 ? 8'h08 : 8'h10});
            case (c)
                3'h0: e = s[5:4];
                3'h1: e = {o3, !o3};
                3'h3: e = {o3, s[2]};
                3'h5: e = {s[3], !o3};
                3'h6: e = s[3:2];
                3'h7: e = s[1:0];
                default: e = 2'h0;
            endcase
            repeat (4) @(posedge mclk);
            chk({30'h0, rom_d, rom_c}, {30'h0, e});
            chk({30'h0, out4, out3}, {30'h0, !o3, o3});
        end
    endtask
    // Reset, then the scenarios in turn
    initial begin
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        t_regs;
        t_pins;
        t_irq;
        t_rom;
        give_verdict;
    end
endmodule
`default_nettype wire

// file: verif/pin_partner.sv
// Board model for the three general pins: pull-ups and an outside driver.
// Assumes the bench never drives a pin that the design is driving.
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
    // Design side
    input  wire logic [2:0] pin_out,
    input  wire logic [2:0] pin_oe,
    // Outside driver
    input  wire logic [2:0] ext_en,
    input  wire logic [2:0] ext_val,
    // Wire level
    output logic [2:0]      level
);
    // A released pin with no outside driver floats up to its pull-up
    assign level = pin_oe & pin_out | ~pin_oe & (ext_en & ext_val | ~ext_en);
endmodule
`default_nettype wire

// file: verilog/gpio_led_pin_config.v
// General pin configuration block: three general pins with indicator
// override, two output-only pins, ROM pin multiplexer and pin interrupts.
// Assumes an Avalon-MM master on MCLK and asynchronous pin inputs.
// Assumes the pads turn PIN_OUT/PIN_OE into two-way pins with pull-ups,
// and that software keeps the ROM function field legal.
//
// Summary of operation
// RQ1: Select bits route pins to indicator outputs.
// RQ2: Polarity bit picks the interrupting pin level.
// RQ3: Interrupt only when pin enable bit set.
// RQ4: Source holds interrupt level over 40 ns.
// RQ5: Function field selects ROM pin signals.
// RQ6: Software keeps function field during ROM cycle.
// RQ7: Software never writes reserved function codes.
// RQ8: Drive bits select push/pull or open-drain.
// RQ9: Direction bits make general pins outputs.
// RQ10: Bits 4:3 drive output-only pins.
// RQ11: Output pins drive their written data bit.
// RQ12: Data bit reads return sampled pin level.
// RQ13: Function codes map to fixed pin pairs.
// RQ14: Inputs synchronised; reserved bits read zero.
`timescale 1ns/100ps
`default_nettype none
`include "gpio_pin_consts.vh"

module gpio_led_pin_config (
    // Clock and reset
    input  wire        MCLK,
    input  wire        NRST,
    // Avalon-MM slave
    input  wire [7:0]  ADDRESS,
    input  wire        READ,
    input  wire        WRITE,
    input  wire [31:0] WRITEDATA,
    input  wire [3:0]  BYTEENABLE,
    output reg  [31:0] READDATA,
    output reg         WAITREQUEST,
    output reg  [1:0]  RESPONSE,
    // Interrupt
    output reg         IRQ,
    // General pins (three signals each)
    input  wire [2:0]  PIN_IN,
    output reg  [2:0]  PIN_OUT,
    output reg  [2:0]  PIN_OE,
    // Indicator sources
    input  wire [2:0]  INDICATOR,
    // Output-only pins when not muxed onto ROM pins
    output reg         OUT_ONLY_PIN_3,
    output reg         OUT_ONLY_PIN_4,
    // ROM pin sources from other logic on MCLK
    input  wire        ROM_DATA_SRC,
    input  wire        ROM_CLK_SRC,
    input  wire        TX_EN,
    input  wire        RX_DV,
    input  wire        TX_CLK,
    input  wire        RX_CLK,
    // ROM pins
    output wire        ROM_DATA_PIN,
    output wire        ROM_CLOCK_PIN
);

    // Configuration fields
    reg  [2:0]  indicator_select;   // 1 = indicator owns the pin
    reg  [2:0]  pin_irq_level_sel;  // 1 = high level interrupts
    reg  [2:0]  rom_pin_function;   // ROM pin function code
    reg  [2:0]  pin_drive_type;     // 1 = push/pull
    reg  [2:0]  pin_direction;      // 1 = output
    reg  [1:0]  out_only_value;     // Values for output-only pins
    reg  [2:0]  pin_value;          // Stored output data
    // Interrupt state
    reg  [2:0]  irq_flag_reg;       // Sticky pin events
    reg  [2:0]  pin_irq_enable;     // Mask
    // Synchronised pins and qualification counters
    wire [2:0]  pin_sync_lvl;
    reg  [3:0]  hit_cnt [0:2];      // Cycles the active level has been seen
    reg  [2:0]  pin_event;          // Qualified level, one per pin
    // Bus decode
    reg         ack;                // Answer phase of a request
    wire        req;
    wire [31:0] cfg_word;
    wire [31:0] wmask;
    reg  [31:0] next_cfg;
    integer     i;                  // Loop index of the qualifier only
    integer     j;                  // Loop index of the pin drivers only

    // Byte enables widened to a bit mask, used on every register write
    function [31:0] lane_mask;
        input [3:0] be;
        begin
            lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    // Masked merge of a three-bit field; lanes not enabled keep old bits
    function [2:0] merge3;
        input [2:0] old_val;
        input [2:0] new_val;
        input [2:0] lanes;
        begin
            merge3 = (old_val & ~lanes) | (new_val & lanes);
        end
    endfunction

    // True while a pin sits at the level that its polarity bit asks for
    function level_hit;
        input lvl;
        input sel;
        begin
            level_hit = (lvl == sel);
        end
    endfunction

    assign req   = (READ | WRITE) & ~ack;
    assign wmask = lane_mask(BYTEENABLE);

    // Readback: data bits show the sampled pins, reserved bits zero
    assign cfg_word = {1'b0, indicator_select, 1'b0, pin_irq_level_sel,
                       1'b0, rom_pin_function, 1'b0, pin_drive_type,
                       5'h00, pin_direction, 3'h0, out_only_value,
                       pin_sync_lvl};  // RQ12 RQ14

    // Pins cross into MCLK before any logic reads them; readback and
    // interrupts both see the levels two cycles late
    pin_sync #(
        .WIDTH    (3)
    ) u_sync (
        .clk      (MCLK),
        .nrst     (NRST),
        .async_in (PIN_IN),
        .sync_out (pin_sync_lvl)
    );  // RQ14

    // Next configuration word after a masked write. The data bits merge
    // into the stored output data, not the readback, so that a write of a
    // neighbouring field never copies the pin levels into the output data
    always @* begin
        next_cfg = (cfg_word & ~(wmask & `CFG_WRITE_MASK))
                 | (WRITEDATA & wmask & `CFG_WRITE_MASK);
        next_cfg[2:0] = merge3(pin_value, WRITEDATA[2:0], wmask[2:0]);
    end

    // Bus handshake: one wait cycle, answer on the second edge.
    // The ack flop stops a request that is still held at the answer edge
    // from being taken twice; the master drops it at that edge.
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ack         <= 1'b0;
            WAITREQUEST <= 1'b1;
            READDATA    <= 32'h00000000;
            RESPONSE    <= 2'h0;
        end else begin
            ack         <= req;
            WAITREQUEST <= ~req;
            RESPONSE    <= 2'h0;
            if (req && READ) begin
                case (ADDRESS)
                    `OFS_PIN_CONFIG: READDATA <= cfg_word;
                    `OFS_IRQ_FLAG:   READDATA <= {29'h0, irq_flag_reg};
                    `OFS_IRQ_ENABLE: READDATA <= {29'h0, pin_irq_enable};
                    default: begin
                        // Unmapped: zero data, slave error
                        READDATA <= 32'h00000000;
                        RESPONSE <= 2'h2;
                    end
                endcase
            end else if (req && WRITE) begin
                READDATA <= 32'h00000000;
                case (ADDRESS)
                    `OFS_PIN_CONFIG, `OFS_IRQ_FLAG, `OFS_IRQ_ENABLE: RESPONSE <= 2'h0;
                    default: RESPONSE <= 2'h2;
                endcase
            end
        end
    end

    // Configuration register; writes take effect with the request edge
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            indicator_select  <= 3'h0;
            pin_irq_level_sel <= 3'h0;
            rom_pin_function  <= 3'h0;
            pin_drive_type    <= 3'h0;
            pin_direction     <= 3'h0;
            out_only_value    <= 2'h0;
            pin_value         <= 3'h0;
            pin_irq_enable    <= `IRQ_RESET;
        end else if (req && WRITE) begin
            if (ADDRESS == `OFS_PIN_CONFIG) begin
                indicator_select  <= next_cfg[`POS_IND_SEL+2:`POS_IND_SEL];
                pin_irq_level_sel <= next_cfg[`POS_IRQ_LEVEL+2:`POS_IRQ_LEVEL];
                // No guard against a change mid ROM cycle; software owns that
                rom_pin_function  <= next_cfg[`POS_ROM_FUNC+2:`POS_ROM_FUNC];  // RQ5
                pin_drive_type    <= next_cfg[`POS_DRIVE_TYPE+2:`POS_DRIVE_TYPE];
                pin_direction     <= next_cfg[`POS_DIRECTION+2:`POS_DIRECTION];
                out_only_value    <= next_cfg[`POS_OUT_ONLY+1:`POS_OUT_ONLY];
                pin_value         <= next_cfg[`POS_PIN_VALUE+2:`POS_PIN_VALUE];
            end
            if (ADDRESS == `OFS_IRQ_ENABLE) begin
                pin_irq_enable <= merge3(pin_irq_enable, WRITEDATA[2:0], wmask[2:0]);
            end
        end
    end

    // Level qualification: the active level must persist for the
    // least hold time; shorter glitches are not flagged.
    // The counter saturates at the hold count, so a level that stays
    // active raises an event every cycle and re-sets its flag after a
    // read clear; the synchroniser adds two cycles of latency.
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            for (i = 0; i < 3; i = i + 1) begin
                hit_cnt[i] <= 4'h0;
            end
            pin_event <= 3'h0;
        end else begin
            for (i = 0; i < 3; i = i + 1) begin
                if (level_hit(pin_sync_lvl[i], pin_irq_level_sel[i])) begin  // RQ2
                    // Saturate so a steady level cannot wrap the counter
                    if (hit_cnt[i] != `PIN_ACTIVE_CYC) begin
                        hit_cnt[i] <= hit_cnt[i] + 4'h1;  // RQ4
                    end
                end else begin
                    // Any inactive sample restarts the hold time
                    hit_cnt[i] <= 4'h0;
                end
                pin_event[i] <= level_hit(pin_sync_lvl[i], pin_irq_level_sel[i])
                             && (hit_cnt[i] == `PIN_ACTIVE_CYC);
            end
        end
    end

    // Sticky flags: read of the flag register clears, a new event wins.
    // The clear loads the events of that same cycle, so none is lost.
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            irq_flag_reg <= `IRQ_RESET;
        end else if (req && READ && ADDRESS == `OFS_IRQ_FLAG) begin
            irq_flag_reg <= pin_event;
        end else begin
            irq_flag_reg <= irq_flag_reg | pin_event;
        end
    end

    // Interrupt level, gated by the enable register.
    // One cycle behind the flags; masking hides a flag but keeps it set.
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_flag_reg & pin_irq_enable);  // RQ3
        end
    end

    // Pin drivers, registered so the pads change only on MCLK; the cost
    // is one cycle from a register write to the pads
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            PIN_OUT        <= 3'h0;
            PIN_OE         <= 3'h0;
            OUT_ONLY_PIN_3 <= 1'b0;
            OUT_ONLY_PIN_4 <= 1'b0;
        end else begin
            for (j = 0; j < 3; j = j + 1) begin
                if (indicator_select[j]) begin
                    // Indicator owns the pin, driven push/pull
                    PIN_OUT[j] <= INDICATOR[j];  // RQ1
                    PIN_OE[j]  <= 1'b1;
                end else if (pin_direction[j]) begin  // RQ9
                    PIN_OUT[j] <= pin_value[j];  // RQ11
                    // Open-drain drives only a low
                    PIN_OE[j]  <= pin_drive_type[j] | ~pin_value[j];  // RQ8
                end else begin
                    // Input: released, the board sets the level
                    PIN_OUT[j] <= 1'b0;
                    PIN_OE[j]  <= 1'b0;
                end
            end
            OUT_ONLY_PIN_3 <= out_only_value[0];  // RQ10
            OUT_ONLY_PIN_4 <= out_only_value[1];
        end
    end

    // ROM pin multiplexer, fed the registered output-only values
    rom_pin_mux u_mux (
        .clk       (MCLK),
        .nrst      (NRST),
        .func      (rom_pin_function),
        .rom_data  (ROM_DATA_SRC),
        .rom_clk   (ROM_CLK_SRC),
        .out3      (out_only_value[0]),
        .out4      (out_only_value[1]),
        .tx_en     (TX_EN),
        .rx_dv     (RX_DV),
        .tx_clk    (TX_CLK),
        .rx_clk    (RX_CLK),
        .data_pin  (ROM_DATA_PIN),
        .clock_pin (ROM_CLOCK_PIN)
    );  // RQ13

endmodule

`default_nettype wire

// file: verilog/gpio_pin_consts.vh
// Constants for the general pin configuration block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
`ifndef GPIO_PIN_CONSTS_VH
`define GPIO_PIN_CONSTS_VH

// Register byte offsets
`define OFS_PIN_CONFIG   8'h88
`define OFS_IRQ_FLAG     8'hA4
`define OFS_IRQ_ENABLE   8'hA8

// Field positions in the configuration register
`define POS_IND_SEL      28
`define POS_IRQ_LEVEL    24
`define POS_ROM_FUNC     20
`define POS_DRIVE_TYPE   16
`define POS_DIRECTION    8
`define POS_OUT_ONLY     3
`define POS_PIN_VALUE    0

// Writable bits of the configuration register
`define CFG_WRITE_MASK   32'h7777071F

// Reset values
`define CFG_RESET        32'h00000000
`define IRQ_RESET        3'h0

// Pin function codes for the ROM pins
`define FUNC_ROM         3'h0
`define FUNC_GPO_BOTH    3'h1
`define FUNC_OUT_ONLY_PIN_3_RXDV   3'h3
`define FUNC_TXEN_OUT_ONLY_PIN_4   3'h5
`define FUNC_TXEN_RXDV   3'h6
`define FUNC_CLOCKS      3'h7

// Least active time of an interrupt input, in ns, and its cycle count at
// the 5 ns clock; the count is sized for the four-bit hold counters
`define PIN_ACTIVE_NS    40
`define CLK_PERIOD_NS    5
`define PIN_ACTIVE_CYC   4'h8

`endif

// file: verilog/pin_sync.v
// Two-stage synchroniser for a bus of pin levels.
// Assumes asynchronous inputs; the first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter WIDTH = 3
) (
    // Clock and reset
    input  wire             clk,
    input  wire             nrst,
    // Levels
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;  // Metastability catcher, read only by stage two

    // Two flops in series
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

`default_nettype wire

// file: verilog/rom_pin_mux.v
// Selects what the ROM data and ROM clock pins carry.
// Assumes all sources are on the block clock; output is registered.
`timescale 1ns/100ps
`default_nettype none
`include "gpio_pin_consts.vh"

module rom_pin_mux (
    // Clock and reset
    input  wire       clk,
    input  wire       nrst,
    // Function select
    input  wire [2:0] func,
    // Sources
    input  wire       rom_data,
    input  wire       rom_clk,
    input  wire       out3,
    input  wire       out4,
    input  wire       tx_en,
    input  wire       rx_dv,
    input  wire       tx_clk,
    input  wire       rx_clk,
    // Pin levels
    output reg        data_pin,
    output reg        clock_pin
);

    reg next_data;  // Selected level for the data pin
    reg next_clock; // Selected level for the clock pin

    // Function table; reserved codes park both pins low
    always @* begin
        next_data  = 1'b0;
        next_clock = 1'b0;
        case (func)
            `FUNC_ROM: begin
                next_data  = rom_data;  // RQ13
                next_clock = rom_clk;
            end
            `FUNC_GPO_BOTH: begin
                next_data  = out3;
                next_clock = out4;
            end
            `FUNC_OUT_ONLY_PIN_3_RXDV: begin
                next_data  = out3;
                next_clock = rx_dv;
            end
            `FUNC_TXEN_OUT_ONLY_PIN_4: begin
                next_data  = tx_en;
                next_clock = out4;
            end
            `FUNC_TXEN_RXDV: begin
                next_data  = tx_en;
                next_clock = rx_dv;
            end
            `FUNC_CLOCKS: begin
                next_data  = tx_clk;
                next_clock = rx_clk;
            end
            default: begin
                // Reserved: software must not pick these
                next_data  = 1'b0;
                next_clock = 1'b0;
            end
        endcase
    end

    // Registered so the top drives straight from flops
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_pin  <= 1'b0;
            clock_pin <= 1'b0;
        end else begin
            data_pin  <= next_data;   // RQ5
            clock_pin <= next_clock;
        end
    end

endmodule

`default_nettype wire
